//--- nand_host_regs.svh
// Timing counts and operation codes for the NAND strobe host.
// Assumes inclusion by bare name from the host module.
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

// Clock period in picoseconds (200 MHz)
`define CLK_PERIOD_PS      5000
// Power-transition recovery, in microseconds
`define RECOVERY_US        10
// Recovery cycles, rounded up
`define RECOVERY_CYCLES    ((`RECOVERY_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Cycles each strobe level is held
`define STROBE_HALF_CYCLES 2
// Operation kind codes on the request port
`define OP_COMMAND         3'h0
`define OP_ADDRESS         3'h1
`define OP_DATA_IN         3'h2
`define OP_DATA_OUT        3'h3
`define OP_STANDBY         3'h4
`define OP_PROTECT         3'h5

`endif

//--- nand_host_pkg.sv
// Types shared by the NAND strobe host.
// Assumes the constants header is on the include path.
package nand_host_pkg;
    // Six standard bus operations
    typedef enum logic [2:0]
    {
        BUS_COMMAND  = 3'h0,
        BUS_ADDRESS  = 3'h1,
        BUS_DATA_IN  = 3'h2,
        BUS_DATA_OUT = 3'h3,
        BUS_STANDBY  = 3'h4,
        BUS_PROTECT  = 3'h5
    } bus_op_t;

    // Control pin bundle driven towards the memory
    typedef struct packed
    {
        logic chip_sel_n;
        logic opcode_phase_sel;
        logic addr_phase_sel;
        logic read_strobe_n;
        logic write_strobe_n;
        logic write_prot_n;
    } ctrl_pins_t;
endpackage : nand_host_pkg

//--- nand_host.sv
// Host controller driving a small-page NAND memory through its pins.
// Assumes pins synchronous to MCLK_IN; ready line pulled up externally.
//
// How it works
// - Wait ten microseconds recovery before commands
// - Keep write strobe high during recovery
// - Drive write protect low at power
// - Idle flag open drain, low means busy
// - Six bus operations from control pins
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_regs.svh"

module nand_host
    import nand_host_pkg::*;
#(
    parameter int RECOVERY_CYCLES = `RECOVERY_CYCLES,
    parameter int DATA_W          = 8
)
(
    input  wire logic              MCLK_IN,
    input  wire logic              RESET_IN,
    input  wire logic              REQ_VALID_IN,
    input  wire logic [2:0]        REQ_OP_IN,
    input  wire logic [DATA_W-1:0] REQ_DATA_IN,
    input  wire logic              WRITE_ENABLE_IN,
    output logic                   REQ_READY_OUT,
    output logic                   RD_VALID_OUT,
    output logic [DATA_W-1:0]      RD_DATA_OUT,
    output logic                   POWER_READY_OUT,
    input  wire logic              IDLE_FLAG_IN,
    input  wire logic [DATA_W-1:0] IO_IN,
    output logic [DATA_W-1:0]      IO_OUT,
    output logic                   IO_OE_OUT,
    output logic                   CHIP_SEL_N_OUT,
    output logic                   OPCODE_PHASE_SEL_OUT,
    output logic                   ADDR_PHASE_SEL_OUT,
    output logic                   READ_STROBE_N_OUT,
    output logic                   WRITE_STROBE_N_OUT,
    output logic                   WRITE_PROT_N_OUT
);

    localparam int CNT_W = $clog2(RECOVERY_CYCLES + 1);
    localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(RECOVERY_CYCLES - 1);
    localparam logic [1:0] HALF_LAST = 2'(`STROBE_HALF_CYCLES - 1);

    // Sequencer states
    typedef enum logic [2:0] {S_RECOVER, S_IDLE, S_LOW, S_HIGH, S_BUSY} state_t;

    state_t             state_q,  state_d;     // Sequencer state
    logic [CNT_W-1:0]   rec_q,    rec_d;       // Recovery counter
    logic [1:0]         half_q,   half_d;      // Strobe phase counter
    bus_op_t            op_q,     op_d;        // Operation in flight
    ctrl_pins_t         pins_q,   pins_d;      // Registered control pins
    logic [DATA_W-1:0]  dout_q,   dout_d;      // Write data on the bus
    logic               oe_q,     oe_d;        // Bus drive enable
    logic [DATA_W-1:0]  rd_q,     rd_d;        // Captured read word
    logic               rdv_q,    rdv_d;       // Read word valid pulse
    logic               idle_s;                // Line released high

    // Pins set for one bus operation
    function automatic ctrl_pins_t op_pins(input bus_op_t op, input logic wp_n);
        ctrl_pins_t p;
        p = '{chip_sel_n: 1'b0, opcode_phase_sel: 1'b0, addr_phase_sel: 1'b0,
              read_strobe_n: 1'b1, write_strobe_n: 1'b1, write_prot_n: wp_n};
        case (op)
            BUS_COMMAND:  p.opcode_phase_sel = 1'b1;
            BUS_ADDRESS:  p.addr_phase_sel = 1'b1;
            BUS_STANDBY:  p.chip_sel_n = 1'b1;
            default:      p.chip_sel_n = 1'b0;
        endcase
        return p;
    endfunction : op_pins

    // low from any memory means busy
    assign idle_s = IDLE_FLAG_IN;
    wire is_read   = (op_q == BUS_DATA_OUT);
    wire is_strobe = (REQ_OP_IN <= `OP_DATA_OUT);
    wire half_done = (half_q == HALF_LAST);

    assign REQ_READY_OUT   = (state_q == S_IDLE) && idle_s;
    assign POWER_READY_OUT = (state_q != S_RECOVER);

    // Next-state sequencing
    always_comb
    begin
        state_d = state_q;
        rec_d   = rec_q;
        half_d  = half_q;
        op_d    = op_q;
        pins_d  = pins_q;
        dout_d  = dout_q;
        oe_d    = oe_q;
        rd_d    = rd_q;
        rdv_d   = 1'b0;
        case (state_q)
            // hold off commands until recovery ends
            S_RECOVER:
            begin
                pins_d = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
                rec_d  = rec_q + CNT_W'(1);
                if (rec_q == REC_LAST)
                begin
                    // then wait for the line to rise
                    state_d = S_BUSY;
                end
            end
            S_IDLE:
            begin
                if (REQ_VALID_IN && idle_s)
                begin
                    op_d   = bus_op_t'(REQ_OP_IN);
                    pins_d = op_pins(bus_op_t'(REQ_OP_IN), WRITE_ENABLE_IN);
                    if (REQ_OP_IN == `OP_PROTECT)
                    begin
                        pins_d.write_prot_n = 1'b0;
                    end
                    dout_d = REQ_DATA_IN;
                    oe_d   = (REQ_OP_IN <= `OP_DATA_IN);
                    half_d = 2'h0;
                    if (is_strobe)
                    begin
                        state_d = S_LOW;
                    end
                end
            end
            S_LOW:
            begin
                if (is_read)
                begin
                    pins_d.read_strobe_n = 1'b0;
                end
                else
                begin
                    pins_d.write_strobe_n = 1'b0;
                end
                half_d = half_q + 2'h1;
                if (half_done && pins_q.read_strobe_n == ~is_read)
                begin
                    half_d  = 2'h0;
                    state_d = S_HIGH;
                    if (is_read)
                    begin
                        rd_d  = IO_IN;
                        rdv_d = 1'b1;
                    end
                end
            end
            S_HIGH:
            begin
                pins_d.read_strobe_n  = 1'b1;
                pins_d.write_strobe_n = 1'b1;
                half_d = half_q + 2'h1;
                if (half_done)
                begin
                    oe_d    = 1'b0;
                    state_d = S_BUSY;
                end
            end
            S_BUSY:
            begin
                // wait for the line to release
                if (idle_s)
                begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_RECOVER;
        endcase
    end

    // State registers
    always_ff @(posedge MCLK_IN)
    begin
        if (RESET_IN)
        begin
            state_q <= S_RECOVER;
            rec_q   <= '0;
            half_q  <= 2'h0;
            op_q    <= BUS_STANDBY;
            pins_q  <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            dout_q  <= '0;
            oe_q    <= 1'b0;
            rd_q    <= '0;
            rdv_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            rec_q   <= rec_d;
            half_q  <= half_d;
            op_q    <= op_d;
            pins_q  <= pins_d;
            dout_q  <= dout_d;
            oe_q    <= oe_d;
            rd_q    <= rd_d;
            rdv_q   <= rdv_d;
        end
    end

    assign IO_OUT               = dout_q;
    assign IO_OE_OUT            = oe_q;
    assign RD_DATA_OUT          = rd_q;
    assign RD_VALID_OUT         = rdv_q;
    assign CHIP_SEL_N_OUT       = pins_q.chip_sel_n;
    assign OPCODE_PHASE_SEL_OUT = pins_q.opcode_phase_sel;
    assign ADDR_PHASE_SEL_OUT   = pins_q.addr_phase_sel;
    assign READ_STROBE_N_OUT    = pins_q.read_strobe_n;
    assign WRITE_STROBE_N_OUT   = pins_q.write_strobe_n;
    assign WRITE_PROT_N_OUT     = pins_q.write_prot_n;

    // Checks
    chk_recovery_strobe_high: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        (state_q == S_RECOVER) |-> (WRITE_STROBE_N_OUT && !WRITE_PROT_N_OUT))
        else $error("Strobe or protect wrong in recovery");
    chk_no_req_recovery: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        !POWER_READY_OUT |-> !REQ_READY_OUT)
        else $error("Request accepted during recovery");
    chk_cmd_phase_pins: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        ($rose(WRITE_STROBE_N_OUT) && OPCODE_PHASE_SEL_OUT) |->
        (!CHIP_SEL_N_OUT && !ADDR_PHASE_SEL_OUT && READ_STROBE_N_OUT))
        else $error("Command phase pins wrong");
    chk_addr_phase_pins: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        ($rose(WRITE_STROBE_N_OUT) && ADDR_PHASE_SEL_OUT) |->
        (!CHIP_SEL_N_OUT && !OPCODE_PHASE_SEL_OUT && READ_STROBE_N_OUT))
        else $error("Address phase pins wrong");
    chk_read_low_hold: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        $fell(READ_STROBE_N_OUT) |=> !READ_STROBE_N_OUT)
        else $error("Read strobe low too short");
    chk_read_sample: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        RD_VALID_OUT |-> (!READ_STROBE_N_OUT && RD_DATA_OUT == $past(IO_IN)))
        else $error("Read word not captured");
    chk_busy_blocks: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        !IDLE_FLAG_IN |-> !REQ_READY_OUT)
        else $error("Request while busy");
    chk_strobes_exclusive: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        !(!READ_STROBE_N_OUT && !WRITE_STROBE_N_OUT))
        else $error("Both strobes low");
    cov_command: cover property (@(posedge MCLK_IN)
        $rose(WRITE_STROBE_N_OUT) && OPCODE_PHASE_SEL_OUT);
    cov_read: cover property (@(posedge MCLK_IN) RD_VALID_OUT);
    cov_busy_wait: cover property (@(posedge MCLK_IN) state_q == S_BUSY && !IDLE_FLAG_IN);

endmodule : nand_host

`default_nettype wire

//--- nand_mem_model.sv
// Behavioural small-page memory answering the strobe host's pins.
// Assumes registered host pins; clk samples strobe edges and times busy and recovery.
`timescale 1ns/1ps
`default_nettype none
module nand_mem_model
    import nand_host_pkg::*;
#(
    parameter int REC_CYC  = 12,
    parameter int BUSY_CYC = 20
)
(
    input  wire logic       clk_in,
    input  wire logic       power_event_in,
    input  wire logic       supply_ok_in,
    input  wire ctrl_pins_t pins_in,
    input  wire logic [7:0] io_bus_in,
    output logic [7:0]      mem_io_out,
    output logic            mem_oe_out,
    output wire logic       idle_flag_out,
    output logic [2:0]      last_kind_out,
    output logic [7:0]      last_byte_out,
    output logic [7:0]      n_latched_out,
    output logic [7:0]      n_prog_out
);
    ctrl_pins_t prev;      // Pins one edge ago
    logic [7:0] col;       // Column counter
    // Word on offer follows the column at once, so it changes on the first clock after the strobe falls
    wire logic [7:0] dout = col ^ 8'hA5;
    int         wait_cnt;  // Recovery or busy time left
    logic [2:0] kind;      // Decoded bus operation
    // Deselected or locked out ignores all
    wire logic sel = !pins_in.chip_sel_n && supply_ok_in;
    assign kind = !pins_in.read_strobe_n ? 3'h7 :
                  {1'b0, pins_in.opcode_phase_sel, pins_in.addr_phase_sel} == 3'h2 ? 3'h0 :
                  {1'b0, pins_in.opcode_phase_sel, pins_in.addr_phase_sel} == 3'h1 ? 3'h1 :
                  {pins_in.opcode_phase_sel, pins_in.addr_phase_sel} == 2'h0 ? 3'h2 : 3'h7;
    // Open drain, low while recovering or busy
    assign idle_flag_out = (wait_cnt > 0) ? 1'b0 : 1'bz;
    // Released bus shows inverse, never a stale copy
    assign mem_oe_out = sel && !pins_in.read_strobe_n;
    assign mem_io_out = mem_oe_out ? dout : ~dout;
    // Strobe edges seen one clock late; the word is combinational so the host
    // samples the current column before the counter moves on
    always @(posedge clk_in)
    begin
        prev <= pins_in;
        if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
        if (power_event_in)
        begin
            wait_cnt  <= REC_CYC;
            n_latched_out <= 8'h00;
            n_prog_out    <= 8'h00;
            col       <= 8'h00;
        end
        else if (sel && prev.write_strobe_n === 1'b0 && pins_in.write_strobe_n)
        begin
            n_latched_out <= n_latched_out + 8'h01;
            last_kind_out <= kind;
            last_byte_out <= io_bus_in;
            if (kind == 3'h1) col <= io_bus_in;
            // Program start, counted only when unprotected
            if (kind == 3'h0 && io_bus_in == 8'h10)
            begin
                wait_cnt <= BUSY_CYC;
                if (pins_in.write_prot_n) n_prog_out <= n_prog_out + 8'h01;
            end
        end
        // Each read strobe fall gives next column
        else if (sel && prev.read_strobe_n === 1'b1 && !pins_in.read_strobe_n)
        begin
            col  <= col + 8'h01;
        end
    end
endmodule : nand_mem_model
`default_nettype wire

//--- nand_strobe_and_busy_signalling_tb_top.sv
// Random and corner-case bench for the NAND strobe host.
// Assumes the memory model file and the design are compiled first.
`timescale 1ns/1ps
`default_nettype none
module nand_strobe_and_busy_signalling_tb_top;
    import nand_host_pkg::*;
    logic mclk, rst, req_valid, we, supply_ok, req_ready, rd_valid, power_ready, io_oe, mem_oe;
    logic [2:0] req_op, last_kind;
    logic [7:0] req_data, rd_data, io_out, io_bus, mem_io, last_byte, n_latched, n_prog;
    wire        idle_flag;
    wire ctrl_pins_t pins;
    int n_errors = 0, n_compared = 0, cycles = 0, seed = 32'hB59B;
    // Shared open-drain ready line
    pullup (idle_flag);
    assign io_bus = io_oe ? io_out : mem_io;
    nand_host #(.RECOVERY_CYCLES(8)) nand_host_inst (.MCLK_IN(mclk), .RESET_IN(rst),
        .REQ_VALID_IN(req_valid), .REQ_OP_IN(req_op), .REQ_DATA_IN(req_data),
        .WRITE_ENABLE_IN(we), .REQ_READY_OUT(req_ready), .RD_VALID_OUT(rd_valid),
        .RD_DATA_OUT(rd_data), .POWER_READY_OUT(power_ready), .IDLE_FLAG_IN(idle_flag),
        .IO_IN(io_bus), .IO_OUT(io_out), .IO_OE_OUT(io_oe),
        .CHIP_SEL_N_OUT(pins.chip_sel_n), .OPCODE_PHASE_SEL_OUT(pins.opcode_phase_sel),
        .ADDR_PHASE_SEL_OUT(pins.addr_phase_sel), .READ_STROBE_N_OUT(pins.read_strobe_n),
        .WRITE_STROBE_N_OUT(pins.write_strobe_n), .WRITE_PROT_N_OUT(pins.write_prot_n));
    nand_mem_model nand_mem_model_inst (.clk_in(mclk), .power_event_in(rst),
        .supply_ok_in(supply_ok), .pins_in(pins), .io_bus_in(io_bus), .mem_io_out(mem_io),
        .mem_oe_out(mem_oe), .idle_flag_out(idle_flag), .last_kind_out(last_kind),
        .last_byte_out(last_byte), .n_latched_out(n_latched), .n_prog_out(n_prog));
    // Expected word for a column
    function automatic logic [7:0] exp_word(input logic [7:0] c);
        return c ^ 8'hA5;
    endfunction : exp_word
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Bounded wait for the host to accept
    task automatic wait_ready();
        for (int i = 0; i < 300 && req_ready !== 1'b1; i++) @(negedge mclk);
        check(req_ready, 1'b1);
    endtask : wait_ready
    // Request held until the edge that takes it
    task automatic do_op(input logic [2:0] op, input logic [7:0] d, input logic w);
        wait_ready();
        req_valid = 1'b1;
        req_op = op;
        req_data = d;
        we = w;
        @(posedge mclk);
        @(negedge mclk);
        req_valid = 1'b0;
    endtask : do_op
    task automatic read_word(input logic [7:0] e);
        do_op(3'h3, 8'h00, 1'b1);
        for (int i = 0; i < 10 && rd_valid !== 1'b1; i++) @(negedge mclk);
        check(rd_valid, 1'b1);
        check(rd_data, e);
    endtask : read_word
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            end_sim();
        end
    end
    initial
    begin
        logic [2:0] op;
        logic [7:0] d;
        logic [7:0] n0;
        rst = 1'b1; req_valid = 1'b0; req_op = 3'h0; req_data = 8'h00; we = 1'b0;
        supply_ok = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        check(power_ready, 1'b0);
        check(pins.write_strobe_n, 1'b1);
        check(pins.write_prot_n, 1'b0);
        repeat (6) @(negedge mclk);
        check(power_ready, 1'b1);
        check(req_ready, 1'b0);
        $display("Test recovery done");
        for (int i = 0; i < 16; i++)
        begin
            op = 3'($unsigned($random(seed)) % 3);
            d = 8'($random(seed));
            if (d == 8'h10) d = 8'h11;
            do_op(op, d, 1'($random(seed)));
            wait_ready();
            check(last_kind, op);
            check(last_byte, d);
        end
        $display("Test latch done");
        d = 8'($random(seed));
        do_op(3'h1, d, 1'b1);
        for (int i = 0; i < 4; i++) read_word(exp_word(d + 8'(i)));
        $display("Test read done");
        n0 = n_prog;
        do_op(3'h0, 8'h10, 1'b1);
        repeat (4) @(negedge mclk);
        check({idle_flag, req_ready}, 2'h0);
        wait_ready();
        check(n_prog, 8'(n0 + 8'h01));
        do_op(3'h5, 8'h00, 1'b0);
        wait_ready();
        check(pins.write_prot_n, 1'b0);
        n0 = n_prog;
        do_op(3'h0, 8'h10, 1'b0);
        wait_ready();
        check(n_prog, n0);
        $display("Test busy and protect done");
        do_op(3'h4, 8'h00, 1'b1);
        wait_ready();
        check({pins.chip_sel_n, mem_oe}, 2'h2);
        supply_ok = 1'b0;
        n0 = n_latched;
        do_op(3'h0, 8'h22, 1'b1);
        wait_ready();
        check(n_latched, n0);
        $display("Test standby and lockout done");
        end_sim();
    end
endmodule : nand_strobe_and_busy_signalling_tb_top
`default_nettype wire
